// >>> hdl/icsc_ctrl.sv
// Interrupt and chip select control register reached by the host in I/O space.
// Assumes the I/O decode presents one-cycle write strobes and reads at any time.
`timescale 1ns/1ps
`include "icsc_defs.svh"
// Summary of operation
// - Byte, word, long writes; documented reset value.
// - Top six bits always read as one.
// - Joystick base select: four bases, eight apart.
// - Input field reads sampled pin levels.
// - Zero drives pin low, one releases.
// - Format bit: left-justified or I2S input.
// - Warm reset bit drives codec warm reset.
// - Record halt blocks record bus transfers.
// - Power change interrupt mask bit.
// - Record source: codec ADC or I2S.
// - Voice interrupt mask for playback, record.
// - Power interrupt while level differs from state.
// - Test memory request blocks memory access.
// - FM playback enable; restart by toggling.
// - Codec playback enable; restart by toggling.
// - Record enable; restart by toggling.
// - MIDI serial port enable bit.
// - Joystick enable bit.
// - Crystal clock gate bit.
// - Bus clock gate, except bus, this unit.
// - Power interrupt reaches pin only when enabled.
module icsc_ctrl
	import icsc_pkg::*;
#(
	parameter int GPIO_W = 4
) (
	input wire logic ref_clk_i, // Bus clock.
	input wire logic arst_n_i, // Async reset, active low.
	input wire logic wr_i, // Write strobe for the control register.
	input wire logic [3:0] be_i, // Byte enables of the write.
	input wire logic [31:0] wdata_i, // Write data.
	input wire logic [1:0] cfg_power_state_i, // Power state from configuration space.
	input wire logic power_irq_enable_i, // Power interrupt enable.
	input wire logic [GPIO_W-1:0] gpio_i, // General purpose pin levels.
	output logic [GPIO_W-1:0] gpio_o, // Pin drive value.
	output logic [GPIO_W-1:0] gpio_oe_o, // Pin drive enable.
	output logic [31:0] rdata_o, // Register read value.
	output icsc_ctrl_s ctrl_o // Controls to the rest of the device.
);
	// All state of the register block.
	typedef struct packed {
		logic [31:0] ctrl;
		icsc_ctrl_s out;
		logic [31:0] rd;
	} icsc_state_s;
	icsc_state_s st_reg;
	icsc_state_s st_next;
	logic [GPIO_W-1:0] gpio_level; // Sampled pin levels.

	// Merges a write into the stored value by byte lane.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return (r & `ICSC_RW_MASK) | `ICSC_ONES_MASK;
	endfunction

	// Pin block; released pins read back through the same sampler.
	icsc_gpio #(.WIDTH(GPIO_W)) u_gpio (
		.ref_clk_i(ref_clk_i),
		.arst_n_i(arst_n_i),
		.out_val_i(st_reg.ctrl[`ICSC_GPIO_OUT_LSB +: GPIO_W]),
		.pin_i(gpio_i),
		.pin_o(gpio_o),
		.pin_oe_o(gpio_oe_o),
		.level_o(gpio_level)
	);

	// Next state: register update, decoded controls and read image.
	always_comb begin
		logic [31:0] c;
		c = st_reg.ctrl;
		st_next = st_reg;
		if (wr_i) begin
			c = merge(st_reg.ctrl, wdata_i, be_i);
		end
		st_next.ctrl = c;
		// Joystick base is 0x200 plus eight per select step.
		st_next.out.joy_base = `ICSC_JOY_BASE0 + {11'h000, c[`ICSC_JOY_LSB +: 2], 3'h0};
		st_next.out.joy_en = c[`ICSC_JOY_EN_BIT];
		st_next.out.midi_en = c[`ICSC_MIDI_EN_BIT];
		// A channel restarts only when its unit sees the enable fall then rise.
		st_next.out.fm_en = c[`ICSC_FM_EN_BIT];
		st_next.out.codec_en = c[`ICSC_CODEC_EN_BIT];
		st_next.out.rec_en = c[`ICSC_REC_EN_BIT];
		st_next.out.rec_halt = c[`ICSC_REC_HALT_BIT];
		st_next.out.rec_src = c[`ICSC_REC_SRC_BIT];
		st_next.out.fmt_i2s = c[`ICSC_FMT_BIT];
		// Pulse length is left to software, the codec sees the bit level.
		st_next.out.warm_reset = c[`ICSC_WARM_BIT];
		st_next.out.mem_block = c[`ICSC_MEMREQ_BIT];
		st_next.out.xtal_gate = c[`ICSC_XTAL_GATE_BIT];
		st_next.out.bus_gate = c[`ICSC_BUS_GATE_BIT];
		st_next.out.voice_irq_en = c[`ICSC_VOICE_MASK_BIT];
		// The request lasts while levels differ; matching them clears it.
		st_next.out.power_irq = (c[`ICSC_CURRENT_POWERDOWN_LEVEL_LSB +: 2] != cfg_power_state_i)
			&& c[`ICSC_PWR_MASK_BIT] && power_irq_enable_i;
		// Read image: ones on top, sampled pin levels in the input field.
		st_next.rd = c | `ICSC_ONES_MASK;
		st_next.rd[`ICSC_GPIO_IN_LSB +: GPIO_W] = gpio_level;
	end

	// State register; reset loads the documented value with pins unknown as zero.
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_reg.ctrl <= `ICSC_RESET_VALUE;
			st_reg.out <= '0;
			st_reg.out.joy_base <= `ICSC_JOY_BASE0;
			st_reg.rd <= `ICSC_RESET_VALUE;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rdata_o = st_reg.rd;
	assign ctrl_o = st_reg.out;
endmodule

// >>> hdl/icsc_defs.svh
// Offsets, field positions, reset values and joystick base and step of the control register.
// Assumes inclusion by bare name from the design modules and the bench.
`ifndef ICSC_DEFS_SVH
`define ICSC_DEFS_SVH
`define ICSC_CTRL_OFFSET 8'h00
`define ICSC_ONES_MASK 32'hfc00_0000
`define ICSC_RESET_VALUE 32'hfc0f_0000
`define ICSC_RW_MASK 32'h030f_ffff
`define ICSC_JOY_LSB 24
`define ICSC_GPIO_IN_LSB 20
`define ICSC_GPIO_OUT_LSB 16
`define ICSC_FMT_BIT 15
`define ICSC_WARM_BIT 14
`define ICSC_REC_HALT_BIT 13
`define ICSC_PWR_MASK_BIT 12
`define ICSC_REC_SRC_BIT 11
`define ICSC_VOICE_MASK_BIT 10
`define ICSC_CURRENT_POWERDOWN_LEVEL_LSB 8
`define ICSC_MEMREQ_BIT 7
`define ICSC_FM_EN_BIT 6
`define ICSC_CODEC_EN_BIT 5
`define ICSC_REC_EN_BIT 4
`define ICSC_MIDI_EN_BIT 3
`define ICSC_JOY_EN_BIT 2
`define ICSC_XTAL_GATE_BIT 1
`define ICSC_BUS_GATE_BIT 0
`define ICSC_JOY_BASE0 16'h0200
`define ICSC_JOY_STEP 16'h0008
`endif

// >>> hdl/icsc_gpio.sv
// Four open-drain style general purpose pins with synchronous input capture.
// Assumes pin inputs are synchronous to the clock.
`timescale 1ns/1ps
`include "icsc_defs.svh"
module icsc_gpio #(
	parameter int WIDTH = 4
) (
	input wire logic ref_clk_i, // Clock.
	input wire logic arst_n_i, // Async reset, active low.
	input wire logic [WIDTH-1:0] out_val_i, // Written output bits.
	input wire logic [WIDTH-1:0] pin_i, // Pin levels.
	output logic [WIDTH-1:0] pin_o, // Pin drive value, always low.
	output logic [WIDTH-1:0] pin_oe_o, // High while pulling the pin low.
	output logic [WIDTH-1:0] level_o // Sampled pin levels.
);
	// All state of the pin block.
	typedef struct packed {
		logic [WIDTH-1:0] oe;
		logic [WIDTH-1:0] lvl;
	} icsc_gpio_state_s;
	icsc_gpio_state_s st_reg;
	icsc_gpio_state_s st_next;
	// A zero bit pulls low; a one releases so the pin may be an input.
	always_comb begin
		st_next = st_reg;
		st_next.oe = ~out_val_i;
		st_next.lvl = pin_i;
	end
	// Released pins rise by the outside pull-up.
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	assign pin_o = '0;
	assign pin_oe_o = st_reg.oe;
	assign level_o = st_reg.lvl;
endmodule

// >>> hdl/icsc_pkg.sv
// Types shared by the control register block.
// Assumes the defs header is on the include path.
package icsc_pkg;
	// Register write request from the I/O decode.
	typedef struct packed {
		logic wr;
		logic [3:0] be;
		logic [31:0] data;
	} icsc_wreq_s;
	// Enables and selects driven to the rest of the device.
	typedef struct packed {
		logic [15:0] joy_base;
		logic joy_en;
		logic midi_en;
		logic fm_en;
		logic codec_en;
		logic rec_en;
		logic rec_halt;
		logic rec_src;
		logic fmt_i2s;
		logic warm_reset;
		logic mem_block;
		logic xtal_gate;
		logic bus_gate;
		logic voice_irq_en;
		logic power_irq;
	} icsc_ctrl_s;
	// Warm reset pulse phases.
	typedef enum logic [1:0] {
		ICSC_WARM_IDLE = 2'b00,
		ICSC_WARM_HIGH = 2'b01
	} icsc_warm_e;
endpackage

// >>> tb/icsc_ctrl_monitor.sv
// Port checker for the control register.
// Assumes it is bound onto icsc_ctrl.
`timescale 1ns/1ps
module icsc_ctrl_monitor
	import icsc_pkg::*;
#(parameter int GPIO_W = 4) (
	input wire logic ref_clk_i, // Clock.
	input wire logic arst_n_i, // Reset.
	input wire logic wr_i, // Strobe.
	input wire logic [3:0] be_i, // Lanes.
	input wire logic [31:0] wdata_i, // Data.
	input wire logic [1:0] cfg_power_state_i, // State.
	input wire logic power_irq_enable_i, // Enable.
	input wire logic [GPIO_W-1:0] gpio_i, // Pins.
	input wire logic [GPIO_W-1:0] gpio_o, // Drive value.
	input wire logic [GPIO_W-1:0] gpio_oe_o, // Pulls.
	input wire logic [31:0] rdata_o, // Image.
	input wire icsc_ctrl_s ctrl_o // Controls.
);
	logic [1:0] up_reg; // Edges since reset, so pin history is valid.
	// Saturating count of edges after reset.
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			up_reg <= 2'h0;
		end else begin
			up_reg <= up_reg + 2'(up_reg != 2'h3);
		end
	end
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i);
	a_top_ones: assert property (rdata_o[31:26] == 6'h3f) else $error("top bits");
	a_lane_load: assert property (wr_i && be_i[1] |=> rdata_o[15:8] == $past(wdata_i[15:8])) else $error("lane");
	a_joy_base: assert property (ctrl_o.joy_base == 16'h0200 + 16'(rdata_o[25:24]) * 16'h0008) else $error("joy");
	a_pin_in: assert property (up_reg == 2'h3 |-> rdata_o[23:20] == $past(gpio_i, 2)) else $error("pin in");
	a_pin_drive: assert property (gpio_oe_o == ~$past(rdata_o[19:16])) else $error("pin drive");
	a_drive_low: assert property (gpio_o == '0) else $error("pin value");
	a_power_irq: assert property ($stable(rdata_o[12:8]) |-> ctrl_o.power_irq == ((rdata_o[9:8] !=
		$past(cfg_power_state_i)) && rdata_o[12] && $past(power_irq_enable_i))) else $error("power irq");
	a_warm_level: assert property (ctrl_o.warm_reset == rdata_o[14]) else $error("warm");
	a_clock_gates: assert property ({ctrl_o.xtal_gate, ctrl_o.bus_gate} == rdata_o[1:0]) else $error("gate");
	cover property (wr_i && be_i == 4'hf);
	cover property (ctrl_o.power_irq);
	cover property (gpio_oe_o != 4'h0);
	cover property (ctrl_o.warm_reset);
endmodule
bind icsc_ctrl icsc_ctrl_monitor #(.GPIO_W(GPIO_W)) u_mon (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
	.wr_i(wr_i), .be_i(be_i), .wdata_i(wdata_i), .cfg_power_state_i(cfg_power_state_i),
	.power_irq_enable_i(power_irq_enable_i), .gpio_i(gpio_i), .gpio_o(gpio_o), .gpio_oe_o(gpio_oe_o),
	.rdata_o(rdata_o), .ctrl_o(ctrl_o));

// >>> tb/icsc_ctrl_tb.sv
// Bench: random writes, pin traffic, power interrupt.
// Assumes design, pin model and checker are compiled.
`timescale 1ns/1ps
`include "icsc_defs.svh"
module icsc_ctrl_tb;
	import icsc_pkg::*;
	logic clk = 0, rst_n = 0, wr = 0, en = 0;
	logic [3:0] be = 4'h0, oe, pins, ext = 4'h0;
	logic [31:0] wd = 32'h0, rd, ev = 32'hfc0f_0000;
	logic [1:0] cfg = 2'h0;
	icsc_ctrl_s ctrl;
	logic [31:0] q[$]; // Expected images.
	logic [31:0] n; // Note taken off the queue.
	logic [28:0] sc, xc; // Seen and expected decoded controls.
	// Stand-in for the codec's minimum warm reset pulse; software must hold at least this long.
	localparam int WARM_HOLD = 16;
	int seed = 60130, mismatches = 0, compares = 0, cyc = 0;
	icsc_ctrl u_dut (.ref_clk_i(clk), .arst_n_i(rst_n), .wr_i(wr), .be_i(be), .wdata_i(wd), .cfg_power_state_i(cfg),
		.power_irq_enable_i(en), .gpio_i(pins), .gpio_o(), .gpio_oe_o(oe), .rdata_o(rd), .ctrl_o(ctrl));
	icsc_pin_model u_pins (.oe_i(oe), .ext_i(ext), .level_o(pins));
	initial forever #4 clk = ~clk;
	task automatic check(input logic [31:0] s, input logic [31:0] w);
		compares++;
		if (s !== w) begin
			mismatches++;
			$display("MISMATCH %0t saw %h want %h", $time, s, w);
		end
	endtask
	task automatic end_of_test;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// One write, then a note of the image it should leave.
	task automatic wr_reg(input logic [3:0] b, input logic [31:0] d);
		logic [31:0] m;
		m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}} & `ICSC_RW_MASK;
		@(posedge clk);
		wr <= 1'b1;
		be <= b;
		wd <= d;
		@(posedge clk);
		wr <= 1'b0;
		ev = (ev & ~m) | (d & m);
		q.push_back(ev);
	endtask
	// Watcher: the oldest note against the image, pin field aside, and against the decoded controls.
	always @(negedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			end_of_test();
		end else if (q.size() > 0) begin
			n = q.pop_front();
			check(rd & 32'hff0f_ffff, n);
			sc = {ctrl.joy_base, ctrl.fmt_i2s, ctrl.warm_reset, ctrl.rec_halt, ctrl.rec_src, ctrl.voice_irq_en,
				ctrl.mem_block, ctrl.fm_en, ctrl.codec_en, ctrl.rec_en, ctrl.midi_en, ctrl.joy_en, ctrl.xtal_gate,
				ctrl.bus_gate};
			xc = {16'(`ICSC_JOY_BASE0 + 16'(n[25:24]) * `ICSC_JOY_STEP), n[15:13], n[11:10], n[7:0]};
			check(32'(sc), 32'(xc));
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		q.push_back(ev);
		// Every lane pattern with random data, pins and power inputs.
		for (int i = 0; i < 64; i++) begin
			cfg <= 2'($random(seed));
			en <= 1'($random(seed));
			ext <= 4'($random(seed));
			wr_reg(i[3:0], $random(seed));
		end
		// Channel restart by clearing then setting the enables, then a held warm reset pulse.
		wr_reg(4'h1, 32'h0000_0000);
		wr_reg(4'h1, 32'h0000_0070);
		wr_reg(4'h2, 32'h0000_4000);
		repeat (WARM_HOLD) @(posedge clk);
		wr_reg(4'h2, 32'h0000_0000);
		cfg <= 2'h3;
		en <= 1'b1;
		wr_reg(4'h2, 32'h0000_1100);
		repeat (2) @(negedge clk);
		check(32'(ctrl.power_irq), 32'h1);
		wr_reg(4'h2, 32'h0000_1300);
		repeat (2) @(negedge clk);
		check(32'(ctrl.power_irq), 32'h0);
		end_of_test();
	end
endmodule

// >>> tb/icsc_pin_model.sv
// Pull-up pins with an outside device able to pull low.
// Assumes an enable high means the design pulls low.
`timescale 1ns/1ps
module icsc_pin_model (
	input wire logic [3:0] oe_i, // Design pulls.
	input wire logic [3:0] ext_i, // Outside pulls.
	output logic [3:0] level_o // Wire level.
);
	// A released pin rises to the pull-up.
	assign level_o = ~(oe_i | ext_i);
endmodule
